// >>> include/svrf_pkg.sv
// shared constants and types for the simd vector register file
`default_nettype none
package svrf_pkg;
    localparam int unsigned NUM_VREGS = 8; // vector and packed-integer register count
    localparam int unsigned VREG_W = 128; // vector register width
    localparam int unsigned PREG_W = 64; // packed-integer register width
    localparam int unsigned LANE_W = 32; // one single-precision lane
    localparam int unsigned NUM_LANES = 4; // lanes per vector register
    localparam int unsigned NUM_BYTES = 16; // bytes per full-width store
    localparam int unsigned IDX_W = 3; // register index width
    // control/status layout
    localparam logic [31:0] CSR_RESET = 32'h0000_1F80; // masks 7..12 set, rest clear
    localparam logic [31:0] CSR_RSVD_MASK = 32'hFFFF_0000; // bits 16..31 reserved
    localparam int unsigned CSR_FLAG_LSB = 0; // exception flags 0..5
    localparam int unsigned CSR_FLAG_W = 6;
    localparam int unsigned CSR_DAZ_BIT = 6; // denormal_input_zero_enable
    localparam int unsigned CSR_MASK_LSB = 7; // exception masks 7..12
    localparam int unsigned CSR_MASK_W = 6;
    localparam int unsigned CSR_RC_LSB = 13; // rounding control 13..14
    localparam int unsigned CSR_RC_W = 2;
    localparam int unsigned CSR_FZ_BIT = 15; // flush_underflow_enable
    // processor_flags_register bits written by compares
    localparam int unsigned FLG_CF_BIT = 0;
    localparam int unsigned FLG_PF_BIT = 2;
    localparam int unsigned FLG_ZF_BIT = 6;
    // processor_identification_query feature word
    localparam int unsigned ID_FEAT_BIT = 25;
    localparam logic [31:0] ID_FEAT_WORD = 32'h0200_0000;
    localparam int unsigned OUTST_W = 4; // outstanding store counter width
    localparam logic [OUTST_W-1:0] OUTST_ONE = 4'h1;
    localparam logic [OUTST_W-1:0] OUTST_MAX = 4'hF;
    // memory access width
    typedef enum logic [1:0] {
        SVRF_W32 = 2'h0,
        SVRF_W64 = 2'h1,
        SVRF_W128 = 2'h2
    } svrf_width_t;
    localparam logic [3:0] LANES_W32 = 4'h1;
    localparam logic [3:0] LANES_W64 = 4'h3;
    localparam logic [3:0] LANES_W128 = 4'hF;
endpackage
`default_nettype wire

// >>> rtl/svrf_top.sv
// simd vector register file: vector, packed-integer and control/status state
`default_nettype none
module svrf_top (
    input wire logic clk,
    input wire logic rst_n,
    // vector load from memory (byte 0 in bits 7:0)
    input wire logic ld_en,
    input wire logic [2:0] ld_idx,
    input wire svrf_pkg::svrf_width_t ld_width,
    input wire logic [127:0] ld_data,
    // scalar or packed result writeback
    input wire logic sc_wr_en,
    input wire logic sc_packed,
    input wire logic [2:0] sc_idx,
    input wire logic [127:0] sc_data,
    // register read port
    input wire logic rd_en,
    input wire logic [2:0] rd_idx,
    output logic [127:0] rd_data_q,
    output logic [31:0] rd_scalar_q,
    // vector store to memory
    input wire logic st_en,
    input wire logic [2:0] st_idx,
    input wire svrf_pkg::svrf_width_t st_width,
    input wire logic [31:0] st_gpr_addr,
    output logic st_ready,
    output logic mem_wr_valid_q,
    output logic [31:0] mem_wr_addr_q,
    output logic [127:0] mem_wr_data_q,
    output logic [15:0] mem_wr_be_q,
    input wire logic mem_wr_ack,
    // store fence
    input wire logic fence_req,
    output logic fence_busy,
    // packed-integer registers and transfers
    input wire logic pi_wr_en,
    input wire logic [2:0] pi_wr_idx,
    input wire logic [63:0] pi_wr_data,
    input wire logic [2:0] pi_rd_idx,
    output logic [63:0] pi_rd_data_q,
    input wire logic xfer_to_vec,
    input wire logic xfer_to_pi,
    input wire logic [2:0] xfer_vidx,
    input wire logic [2:0] xfer_pidx,
    // control/status access
    input wire logic csr_ld_en,
    input wire logic csr_rst_en,
    input wire logic [31:0] csr_wdata,
    input wire logic csr_st_en,
    input wire logic csr_save_en,
    output logic [31:0] csr_st_data_q,
    output logic csr_st_valid_q,
    output logic gp_fault_q,
    output logic [31:0] csr_q,
    // exception flags raised by execution
    input wire logic exc_set_en,
    input wire logic [5:0] exc_flags,
    // compare result to processor flags register
    input wire logic cmp_en,
    input wire logic cmp_zf,
    input wire logic cmp_pf,
    input wire logic cmp_cf,
    output logic flags_upd_valid_q,
    output logic [31:0] flags_upd_q,
    // identification query feature word
    output logic [31:0] id_feat_q
);
    // lane enables for a memory access width
    function automatic logic [3:0] width_lanes(input svrf_pkg::svrf_width_t w);
        unique case (w)
            svrf_pkg::SVRF_W32: width_lanes = svrf_pkg::LANES_W32;
            svrf_pkg::SVRF_W64: width_lanes = svrf_pkg::LANES_W64;
            default: width_lanes = svrf_pkg::LANES_W128; // illegal code taken as full width
        endcase
    endfunction

    // byte enables for a store: one per byte, four per lane
    function automatic logic [15:0] lanes_to_be(input logic [3:0] l);
        lanes_to_be = {{4{l[3]}}, {4{l[2]}}, {4{l[1]}}, {4{l[0]}}};
    endfunction

    // storage: two distinct arrays, so no index can reach the other file
    logic [127:0] vec_q [8]; // vector registers
    logic [63:0] pi_q [8]; // packed-integer registers

    // vector write mux: load beats scalar result beats transfer
    logic vw_en; // any vector write this cycle
    logic [2:0] vw_idx; // destination register
    logic [3:0] vw_lanes; // lanes written
    logic [127:0] vw_data; // write data
    logic [3:0] sc_lanes; // lanes a result writes
    // scalar results only hit lane 0; packed results hit all four
    assign sc_lanes = sc_packed ? svrf_pkg::LANES_W128 : svrf_pkg::LANES_W32;
    assign vw_en = ld_en | sc_wr_en | xfer_to_vec;
    assign vw_idx = ld_en ? ld_idx : (sc_wr_en ? sc_idx : xfer_vidx);
    // loads of 32 or 64 bits fill the low lanes only; 128-bit loads fill all four lanes
    assign vw_lanes = ld_en ? width_lanes(ld_width) : (sc_wr_en ? sc_lanes : svrf_pkg::LANES_W64);
    assign vw_data = ld_en ? ld_data : (sc_wr_en ? sc_data : {64'h0, pi_q[xfer_pidx]});

    // vector register update, lane by lane; no gating by operating mode
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int r = 0; r < svrf_pkg::NUM_VREGS; r++) vec_q[r] <= 128'h0;
        end else if (vw_en) begin
            for (int l = 0; l < svrf_pkg::NUM_LANES; l++) begin
                if (vw_lanes[l]) begin
                    vec_q[vw_idx][l*svrf_pkg::LANE_W +: svrf_pkg::LANE_W] <=
                        vw_data[l*svrf_pkg::LANE_W +: svrf_pkg::LANE_W];
                end
            end
        end
    end

    // packed-integer update; direct write wins over a transfer from a vector
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int r = 0; r < svrf_pkg::NUM_VREGS; r++) pi_q[r] <= 64'h0;
        end else if (pi_wr_en) begin
            pi_q[pi_wr_idx] <= pi_wr_data;
        end else if (xfer_to_pi) begin
            pi_q[xfer_pidx] <= vec_q[xfer_vidx][63:0];
        end
    end

    // registered read ports
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_q <= 128'h0;
            rd_scalar_q <= 32'h0;
            pi_rd_data_q <= 64'h0;
        end else begin
            if (rd_en) begin
                rd_data_q <= vec_q[rd_idx];
                rd_scalar_q <= vec_q[rd_idx][31:0]; // scalar operand is low doubleword
            end
            pi_rd_data_q <= pi_q[pi_rd_idx];
        end
    end

    // store path and fence bookkeeping
    logic fence_pend_q; // fence waiting for older stores
    logic [3:0] outst_q; // stores sent but not yet acknowledged
    logic st_fire; // a store is accepted
    logic [127:0] st_src; // register being stored
    assign st_src = vec_q[st_idx];
    // while a fence drains, later stores are held back
    assign st_ready = !fence_pend_q && (outst_q != svrf_pkg::OUTST_MAX);
    assign st_fire = st_en && st_ready;
    assign fence_busy = fence_pend_q;

    // memory write: byte k of the register goes to address + k
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_wr_valid_q <= 1'b0;
            mem_wr_addr_q <= 32'h0;
            mem_wr_data_q <= 128'h0;
            mem_wr_be_q <= 16'h0;
        end else begin
            mem_wr_valid_q <= st_fire;
            if (st_fire) begin
                mem_wr_addr_q <= st_gpr_addr; // address only from general registers
                mem_wr_data_q <= st_src; // little-endian layout needs no swap
                mem_wr_be_q <= lanes_to_be(width_lanes(st_width));
            end
        end
    end

    // count outstanding stores; fence clears only when all older ones are acked
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            outst_q <= 4'h0;
            fence_pend_q <= 1'b0;
        end else begin
            if (st_fire && !mem_wr_ack) outst_q <= outst_q + svrf_pkg::OUTST_ONE;
            else if (!st_fire && mem_wr_ack && outst_q != 4'h0) outst_q <= outst_q - svrf_pkg::OUTST_ONE;
            if (fence_req) fence_pend_q <= 1'b1;
            else if (fence_pend_q && outst_q == 4'h0 && !mem_wr_valid_q) fence_pend_q <= 1'b0;
        end
    end

    // control/status write decode
    logic csr_wr; // load or restore requested
    logic csr_bad; // reserved bits nonzero
    logic csr_ok; // write may proceed
    logic [31:0] csr_base; // value before flags are merged
    logic [31:0] csr_d; // next control/status
    assign csr_wr = csr_ld_en | csr_rst_en;
    assign csr_bad = |(csr_wdata & svrf_pkg::CSR_RSVD_MASK);
    assign csr_ok = csr_wr && !csr_bad; // faulting write is dropped whole
    assign csr_base = csr_ok ? csr_wdata : csr_q;
    // set wins over a clearing write in the same cycle, so no event is lost
    assign csr_d = (csr_base | (exc_set_en ? {26'h0, exc_flags} : 32'h0)) & ~svrf_pkg::CSR_RSVD_MASK;

    // control/status register; reset sets masks, clears modes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            csr_q <= svrf_pkg::CSR_RESET;
            gp_fault_q <= 1'b0;
            csr_st_valid_q <= 1'b0;
            csr_st_data_q <= 32'h0;
        end else begin
            csr_q <= csr_d;
            gp_fault_q <= csr_wr && csr_bad; // one-cycle fault pulse
            csr_st_valid_q <= csr_st_en | csr_save_en; // store or save copy
            if (csr_st_en | csr_save_en) csr_st_data_q <= csr_q;
        end
    end

    // compare outcome to processor flags register; other bits cleared
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flags_upd_valid_q <= 1'b0;
            flags_upd_q <= 32'h0;
            id_feat_q <= 32'h0;
        end else begin
            flags_upd_valid_q <= cmp_en;
            if (cmp_en) begin
                flags_upd_q <= 32'h0;
                flags_upd_q[svrf_pkg::FLG_ZF_BIT] <= cmp_zf;
                flags_upd_q[svrf_pkg::FLG_PF_BIT] <= cmp_pf;
                flags_upd_q[svrf_pkg::FLG_CF_BIT] <= cmp_cf;
            end
            id_feat_q <= svrf_pkg::ID_FEAT_WORD; // extension present
        end
    end

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_rsvd_zero;
        (csr_q & svrf_pkg::CSR_RSVD_MASK) == 32'h0;
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved control bits set");

    property p_gp_fault;
        csr_wr && csr_bad |=> gp_fault_q;
    endproperty
    a_gp_fault: assert property (p_gp_fault) else $error("missing fault on reserved write");

    property p_gp_hold;
        csr_wr && csr_bad && !exc_set_en |=> csr_q == $past(csr_q);
    endproperty
    a_gp_hold: assert property (p_gp_hold) else $error("faulting write changed control");

    property p_csr_load;
        csr_ok && !exc_set_en |=> csr_q == $past(csr_wdata) && !gp_fault_q;
    endproperty
    a_csr_load: assert property (p_csr_load) else $error("control load lost");

    property p_sticky;
        exc_set_en && exc_flags[0] |=> csr_q[0] ##1 (csr_q[0] || $past(csr_ok));
    endproperty
    a_sticky: assert property (p_sticky) else $error("exception flag not sticky");

    property p_store_bytes;
        st_fire && st_width == svrf_pkg::SVRF_W128 |=>
            mem_wr_valid_q && mem_wr_be_q == 16'hFFFF && mem_wr_data_q[7:0] == $past(st_src[7:0]);
    endproperty
    a_store_bytes: assert property (p_store_bytes) else $error("full store layout wrong");

    property p_scalar_low;
        sc_wr_en && !sc_packed && !ld_en |=> vec_q[$past(sc_idx)][127:32] == $past(vec_q[sc_idx][127:32]);
    endproperty
    a_scalar_low: assert property (p_scalar_low) else $error("scalar write hit upper lanes");

    property p_fence;
        fence_req |=> !st_ready;
    endproperty
    a_fence: assert property (p_fence) else $error("store accepted past fence");

    property p_flags;
        cmp_en |=> flags_upd_valid_q && flags_upd_q[svrf_pkg::FLG_ZF_BIT] == $past(cmp_zf);
    endproperty
    a_flags: assert property (p_flags) else $error("compare flags not reported");

    property p_cov_fault;
        csr_wr && csr_bad ##1 gp_fault_q;
    endproperty
    c_cov_fault: cover property (p_cov_fault);

    property p_cov_fence;
        fence_pend_q ##1 !fence_pend_q;
    endproperty
    c_cov_fence: cover property (p_cov_fence);

    property p_cov_store;
        st_fire && st_width == svrf_pkg::SVRF_W128;
    endproperty
    c_cov_store: cover property (p_cov_store);

endmodule // svrf_top
`default_nettype wire

// >>> tb/svrf_mem_model.sv
// memory-side partner: takes stores byte by byte and acknowledges them
`default_nettype none
module svrf_mem_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic slow, // stretch the gap between acknowledges
    input wire logic mem_wr_valid_q,
    input wire logic [31:0] mem_wr_addr_q,
    input wire logic [127:0] mem_wr_data_q,
    input wire logic [15:0] mem_wr_be_q,
    output logic mem_wr_ack
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [logic [31:0]]; // sparse byte memory
    int pend; // stores taken, not yet acknowledged
    int wait_c; // cycles before the next acknowledge
    // capture enabled bytes, then acknowledge one store at a time
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pend = 0;
            wait_c = 0;
            mem_wr_ack <= 1'b0;
        end else begin
            mem_wr_ack <= 1'b0;
            if (pend > 0 && wait_c == 0) begin
                mem_wr_ack <= 1'b1;
                pend = pend - 1;
                wait_c = slow ? 6 : 0; // slow mode makes the fence wait
            end else if (wait_c > 0) begin
                wait_c = wait_c - 1;
            end
            if (mem_wr_valid_q) begin
                pend = pend + 1;
                for (int k = 0; k < 16; k++) begin
                    if (mem_wr_be_q[k]) mem[mem_wr_addr_q + k] = mem_wr_data_q[8*k +: 8];
                end
            end
        end
    end
endmodule // svrf_mem_model
`default_nettype wire

// >>> tb/test_simd_vector_register_file.sv
// self-checking bench for the simd vector register file
`default_nettype none
module test_simd_vector_register_file;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_n, ld_en, sc_wr_en, sc_packed, rd_en, st_en, fence_req, pi_wr_en, xfer_to_vec, xfer_to_pi;
    logic csr_ld_en, csr_rst_en, csr_st_en, csr_save_en, exc_set_en, cmp_en, cmp_zf, cmp_pf, cmp_cf, slow;
    logic [2:0] ld_idx, sc_idx, rd_idx, st_idx, pi_wr_idx, pi_rd_idx, xfer_vidx, xfer_pidx;
    svrf_pkg::svrf_width_t ld_width, st_width;
    logic [127:0] ld_data, sc_data, rd_data_q, mem_wr_data_q;
    logic [63:0] pi_wr_data, pi_rd_data_q;
    logic [31:0] st_gpr_addr, mem_wr_addr_q, csr_wdata, csr_st_data_q, csr_q, flags_upd_q, id_feat_q, rd_scalar_q;
    logic [15:0] mem_wr_be_q;
    logic [5:0] exc_flags;
    logic st_ready, mem_wr_valid_q, mem_wr_ack, fence_busy, csr_st_valid_q, gp_fault_q, flags_upd_valid_q;
    logic [127:0] shadow [8]; // expected register contents
    logic [31:0] ecsr; // expected control/status
    logic [31:0] rng = 32'h0000_0033; // xorshift state, fixed seed
    int errors = 0, comparisons = 0, cycles = 0;
    svrf_top u_dut (.clk, .rst_n, .ld_en, .ld_idx, .ld_width, .ld_data, .sc_wr_en, .sc_packed, .sc_idx,
        .sc_data, .rd_en, .rd_idx, .rd_data_q, .rd_scalar_q, .st_en, .st_idx, .st_width, .st_gpr_addr, .st_ready,
        .mem_wr_valid_q, .mem_wr_addr_q, .mem_wr_data_q, .mem_wr_be_q, .mem_wr_ack, .fence_req, .fence_busy,
        .pi_wr_en, .pi_wr_idx, .pi_wr_data, .pi_rd_idx, .pi_rd_data_q, .xfer_to_vec, .xfer_to_pi, .xfer_vidx,
        .xfer_pidx, .csr_ld_en, .csr_rst_en, .csr_wdata, .csr_st_en, .csr_save_en, .csr_st_data_q,
        .csr_st_valid_q, .gp_fault_q, .csr_q, .exc_set_en, .exc_flags, .cmp_en, .cmp_zf, .cmp_pf, .cmp_cf,
        .flags_upd_valid_q, .flags_upd_q, .id_feat_q);
    svrf_mem_model u_mem (.clk, .rst_n, .slow, .mem_wr_valid_q, .mem_wr_addr_q, .mem_wr_data_q, .mem_wr_be_q,
        .mem_wr_ack);
    function automatic logic [31:0] xs();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction
    // low lanes of the access width change, upper lanes keep their value
    function automatic logic [127:0] merge(input logic [127:0] o, input logic [127:0] n, input int lanes);
        for (int l = 0; l < lanes; l++) o[32*l +: 32] = n[32*l +: 32];
        return o;
    endfunction
    // byte enables expected for an access width: four bytes per lane
    function automatic logic [15:0] exp_be(input svrf_pkg::svrf_width_t w);
        return w == svrf_pkg::SVRF_W32 ? 16'h000F : (w == svrf_pkg::SVRF_W64 ? 16'h00FF : 16'hFFFF);
    endfunction
    task automatic chk(input logic [127:0] got, input logic [127:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wrap_up();
        $display("errors=%0d comparisons=%0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic load(input logic [2:0] i, input svrf_pkg::svrf_width_t w, input logic [127:0] d);
        ld_en = 1'b1;
        ld_idx = i;
        ld_width = w;
        ld_data = d;
        @(negedge clk);
        ld_en = 1'b0;
        shadow[i] = merge(shadow[i], d, w == svrf_pkg::SVRF_W32 ? 1 : (w == svrf_pkg::SVRF_W64 ? 2 : 4));
        @(negedge clk); // idle cycle, so a following call never re-raises the strobe in the same step
    endtask
    task automatic rd(input logic [2:0] i);
        rd_en = 1'b1;
        rd_idx = i;
        @(negedge clk);
        rd_en = 1'b0;
        chk(rd_data_q, shadow[i]);
        chk(rd_scalar_q, shadow[i][31:0]);
        @(negedge clk); // idle cycle between read requests
    endtask
    // store request is held until the block can take it
    task automatic st(input logic [2:0] i, input svrf_pkg::svrf_width_t w, input logic [31:0] a);
        st_en = 1'b1;
        st_idx = i;
        st_width = w;
        st_gpr_addr = a;
        while (!st_ready) @(negedge clk);
        @(negedge clk);
        st_en = 1'b0;
        chk(mem_wr_valid_q, 1'b1);
        chk(mem_wr_addr_q, a);
        chk(mem_wr_be_q, exp_be(w));
        chk(mem_wr_data_q, shadow[i]);
        @(negedge clk); // idle cycle between store requests
    endtask
    task automatic csr_wr(input logic rst, input logic [31:0] d);
        csr_ld_en = !rst;
        csr_rst_en = rst;
        csr_wdata = d;
        @(negedge clk);
        csr_ld_en = 1'b0;
        csr_rst_en = 1'b0;
        chk(gp_fault_q, d[31:16] != 16'h0000);
        if (d[31:16] == 16'h0000) ecsr = d;
        chk(csr_q, ecsr);
        @(negedge clk); // idle cycle between control writes
    endtask
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            wrap_up();
        end
    end
    initial begin
        {ld_en, sc_wr_en, sc_packed, rd_en, st_en, fence_req, pi_wr_en, xfer_to_vec, xfer_to_pi, slow} = '0;
        {csr_ld_en, csr_rst_en, csr_st_en, csr_save_en, exc_set_en, cmp_en, cmp_zf, cmp_pf, cmp_cf} = '0;
        {ld_idx, sc_idx, rd_idx, st_idx, pi_wr_idx, pi_rd_idx, xfer_vidx, xfer_pidx} = '0;
        ld_width = svrf_pkg::SVRF_W32;
        st_width = svrf_pkg::SVRF_W32;
        {ld_data, sc_data, pi_wr_data, st_gpr_addr, csr_wdata, exc_flags} = '0;
        rst_n = 1'b0;
        repeat (10) @(negedge clk);
        chk(csr_q, 32'h0000_1F80);
        rst_n = 1'b1;
        @(negedge clk);
        chk(id_feat_q, 32'h0200_0000);
        for (int i = 0; i < 8; i++) load(i[2:0], svrf_pkg::SVRF_W128, {xs(), xs(), xs(), xs()});
        for (int i = 0; i < 8; i++) rd(i[2:0]);
        load(3'h3, svrf_pkg::SVRF_W32, {xs(), xs(), xs(), xs()});
        load(3'h5, svrf_pkg::SVRF_W64, {xs(), xs(), xs(), xs()});
        rd(3'h3);
        rd(3'h5);
        // the unused width code is taken as a full-width load
        load(3'h0, svrf_pkg::svrf_width_t'(2'h3), {xs(), xs(), xs(), xs()});
        rd(3'h0);
        // scalar result lands in lane 0 only, packed result in all four lanes
        for (int p = 0; p < 2; p++) begin
            sc_wr_en = 1'b1;
            sc_packed = p[0];
            sc_idx = 3'h6;
            sc_data = {xs(), xs(), xs(), xs()};
            @(negedge clk);
            sc_wr_en = 1'b0;
            shadow[6] = merge(shadow[6], sc_data, p ? 4 : 1);
            rd(3'h6);
        end
        // packed-integer register feeds and receives the vector low quadword
        pi_wr_en = 1'b1;
        pi_wr_idx = 3'h4;
        pi_wr_data = {xs(), xs()};
        @(negedge clk);
        pi_wr_en = 1'b0;
        xfer_to_vec = 1'b1;
        xfer_vidx = 3'h1;
        xfer_pidx = 3'h4;
        @(negedge clk);
        xfer_to_vec = 1'b0;
        shadow[1][63:0] = pi_wr_data;
        rd(3'h1);
        xfer_to_pi = 1'b1;
        xfer_vidx = 3'h7;
        xfer_pidx = 3'h2;
        pi_rd_idx = 3'h2;
        @(negedge clk);
        xfer_to_pi = 1'b0;
        @(negedge clk);
        chk(pi_rd_data_q, shadow[7][63:0]);
        // each width, then bytes in memory ascend from the register's low byte
        for (int w = 0; w < 3; w++) st(3'h2, svrf_pkg::svrf_width_t'(w), 32'h0000_1000 + 32 * w);
        @(negedge clk);
        for (int k = 0; k < 16; k++) chk(u_mem.mem[32'h0000_1040 + k], shadow[2][8*k +: 8]);
        // slow memory: fence holds later stores until all earlier ones are acknowledged
        slow = 1'b1;
        for (int i = 0; i < 3; i++) st(i[2:0], svrf_pkg::SVRF_W128, {xs()} & 32'h0000_FFF0);
        fence_req = 1'b1;
        @(negedge clk);
        fence_req = 1'b0;
        chk({fence_busy, st_ready}, 2'b10);
        while (fence_busy) @(negedge clk);
        chk(u_mem.pend, 0);
        slow = 1'b0;
        // load and restore paths, good and faulting values, then store and save
        for (int r = 0; r < 2; r++) begin
            csr_wr(r[0], 32'h0000_9FC0);
            csr_wr(r[0], {xs()} & 32'h0000_FFFF);
            csr_wr(r[0], {xs()} | 32'h0001_0000);
            csr_st_en = !r[0];
            csr_save_en = r[0];
            @(negedge clk);
            {csr_st_en, csr_save_en} = 2'b00;
            chk({csr_st_valid_q, csr_st_data_q}, {1'b1, ecsr});
        end
        // raised flags survive idle cycles and clear only by writing zero
        csr_wr(1'b0, 32'h0000_FFC0);
        exc_set_en = 1'b1;
        exc_flags = 6'h3F;
        @(negedge clk);
        exc_set_en = 1'b0;
        repeat (3) @(negedge clk);
        chk(csr_q, 32'h0000_FFFF);
        csr_wr(1'b0, 32'h0000_FFC0);
        // every compare outcome combination
        for (int c = 0; c < 8; c++) begin
            cmp_en = 1'b1;
            {cmp_zf, cmp_pf, cmp_cf} = c[2:0];
            @(negedge clk);
            cmp_en = 1'b0;
            chk({flags_upd_valid_q, flags_upd_q}, {1'b1, 25'h0, c[2], 3'h0, c[1], 1'b0, c[0]});
            @(negedge clk); // idle cycle between compares
        end
        // second reset in mid-run restores the control defaults
        rst_n = 1'b0;
        @(negedge clk);
        chk(csr_q, 32'h0000_1F80);
        rst_n = 1'b1;
        @(negedge clk);
        wrap_up();
    end
endmodule // test_simd_vector_register_file
`default_nettype wire
